// File: ilm_core.sv
/* core model: special register read and write cycles.
   assumes the bench clock; one access at a time. */
`timescale 1ns/10ps
module ilm_core
   import ilm_pkg::*;
(
   input wire logic clk,
   output ilm_sfr_req_t req,
   input wire logic [7:0] rdata
);
   initial req = '0;
   // writes also wait a cycle, so the next access sees settled state
   task automatic acc(input logic w, input logic [7:0] a, d,
      output logic [7:0] q);
      @(posedge clk) req <= {w, !w, a, d}; // write 0 clears flag
      @(posedge clk) req <= {2'h0, ~a, ~d};
      @(posedge clk) q = rdata;
   endtask
endmodule

// File: ilm_level_mask.sv
/*
 * level enable mask, serial pending flags and masked level requests.
 * assumes the core issues one-cycle rd/wr strobes on clk, sources
 * are on clk, and port 0 pins are asynchronous.
 */
// Contract
// - the mask holds one bit per level, 0 masks and 1 unmasks.
// - port 0 pins 4 to 7 request on level 7.
// - port 0 pins 0 to 3 request on level 6.
// - level 5 gathers uart transmit, uart receive and watch timer.
// - level 3 takes timer 1 match and overflow, level 2 timer 0 match.
// - level 1 takes timer b match, level 0 timer a match and overflow.
// - a masked level shows no request to the core from one cycle after the mask write.
// - a pending flag reads 0 when idle and writing 0 clears it.
`timescale 1ns/10ps
module ilm_level_mask
   import ilm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ilm_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic [7:0] port0_pin,
   input wire ilm_src_t src,
   output logic [7:0] level_req
);
   ilm_state_t s_q;
   ilm_state_t s_d;
   logic [7:0] raw;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // first stage feeds only the second
      s_d.pin_s1 = port0_pin;
      s_d.pin_s2 = s_q.pin_s1;
      if (sfr_req.wr && sfr_req.addr == ILM_LEVEL_ENABLE_MASK_ADDR) begin
         s_d.mask = sfr_req.wdata;
      end
      // write-0 clears, write-1 keeps; the set term is or-ed last
      if (sfr_req.wr && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR) begin
         s_d.pend = s_q.pend & sfr_req.wdata[5:0];
      end
      s_d.pend = s_d.pend | src.pend_event;
      raw = '0;
      raw[ILM_LV_P0_HI] = |s_q.pin_s2[7:4];
      raw[ILM_LV_P0_LO] = |s_q.pin_s2[3:0];
      raw[ILM_LV_UART] = s_q.pend[ILM_PB_UART_TX]
         | s_q.pend[ILM_PB_UART_RX] | src.watch_timer_req;
      raw[ILM_LV_SER] = src.serial_req;
      raw[ILM_LV_T1] = s_q.pend[ILM_PB_T1_CAP]
         | s_q.pend[ILM_PB_T1_OVF];
      raw[ILM_LV_T0] = src.t0_match_req;
      raw[ILM_LV_TB] = src.tb_match_req;
      raw[ILM_LV_TA] = s_q.pend[ILM_PB_TA_CAP]
         | s_q.pend[ILM_PB_TA_OVF];
      s_d.level_req = raw & s_q.mask;
      if (sfr_req.rd) begin
         case (sfr_req.addr)
            ILM_LEVEL_ENABLE_MASK_ADDR: begin
               s_d.rdata = s_q.mask;
            end
            ILM_SERIAL_PENDING_FLAGS_ADDR: begin
               s_d.rdata = {ILM_PEND_UNUSED, s_q.pend};
            end
            default: begin
               s_d.rdata = ILM_READ_UNMAPPED;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q.mask <= ILM_MASK_RESET;
         s_q.pend <= ILM_PEND_RESET;
         s_q.pin_s1 <= '0;
         s_q.pin_s2 <= '0;
         s_q.level_req <= '0;
         s_q.rdata <= ILM_READ_UNMAPPED;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata = s_q.rdata;
   assign level_req = s_q.level_req;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // core spaces its accesses, so check write and readback apart
   property p_mask_write;
      sfr_req.wr && sfr_req.addr == ILM_LEVEL_ENABLE_MASK_ADDR
         |=> s_q.mask == $past(sfr_req.wdata);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask write did not land");

   property p_mask_read;
      sfr_req.rd && sfr_req.addr == ILM_LEVEL_ENABLE_MASK_ADDR
         |=> sfr_rdata == $past(s_q.mask);
   endproperty
   a_mask_read: assert property (p_mask_read)
      else $error("mask readback differs from mask");

   property p_mask_hold;
      !(sfr_req.wr && sfr_req.addr == ILM_LEVEL_ENABLE_MASK_ADDR)
         |=> $stable(s_q.mask);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("mask changed without a mask write");

   property p_hi_pins;
      (|s_q.pin_s2[7:4]) && s_q.mask[7] |=> level_req[7];
   endproperty
   a_hi_pins: assert property (p_hi_pins)
      else $error("level 7 missing for pins 4-7");

   property p_lo_pins;
      (|s_q.pin_s2[3:0]) && s_q.mask[6] |=> level_req[6];
   endproperty
   a_lo_pins: assert property (p_lo_pins)
      else $error("level 6 missing for pins 0-3");

   property p_uart_level;
      src.watch_timer_req && s_q.mask[5] |=> level_req[5];
   endproperty
   a_uart_level: assert property (p_uart_level)
      else $error("level 5 missing for watch timer");

   property p_t1_level;
      s_q.pend[ILM_PB_T1_OVF] && s_q.mask[3] |=> level_req[3];
   endproperty
   a_t1_level: assert property (p_t1_level)
      else $error("level 3 missing for timer 1");

   property p_ta_level;
      s_q.pend[ILM_PB_TA_CAP] && s_q.mask[0] |=> level_req[0];
   endproperty
   a_ta_level: assert property (p_ta_level)
      else $error("level 0 missing for timer a");

   property p_masked;
      (level_req & ~$past(s_q.mask)) == 8'h00;
   endproperty
   a_masked: assert property (p_masked)
      else $error("masked level shown to core");

   property p_rx_read;
      sfr_req.rd && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR
         |=> sfr_rdata[5] == $past(s_q.pend[ILM_PB_UART_RX])
         && sfr_rdata[7:6] == 2'h0;
   endproperty
   a_rx_read: assert property (p_rx_read)
      else $error("pending readback wrong");

   property p_clear;
      sfr_req.wr && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR
         && !sfr_req.wdata[4] && !src.pend_event[4]
         |=> !s_q.pend[ILM_PB_UART_TX];
   endproperty
   a_clear: assert property (p_clear)
      else $error("write 0 did not clear tx flag");

   // a clear right after the event is legal, so check hold per cycle
   property p_set_wins;
      src.pend_event[ILM_PB_UART_RX] || (s_q.pend[ILM_PB_UART_RX]
         && !(sfr_req.wr && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR
         && !sfr_req.wdata[ILM_PB_UART_RX])) |=> s_q.pend[ILM_PB_UART_RX];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("rx event lost or not held");

   property p_hi_quiet;
      !(|s_q.pin_s2[7:4]) |=> !level_req[ILM_LV_P0_HI];
   endproperty
   a_hi_quiet: assert property (p_hi_quiet)
      else $error("level 7 without a pin request");

   property p_lo_quiet;
      !(|s_q.pin_s2[3:0]) |=> !level_req[ILM_LV_P0_LO];
   endproperty
   a_lo_quiet: assert property (p_lo_quiet)
      else $error("level 6 without a pin request");

   property p_flags_level;
      (s_q.pend[ILM_PB_UART_TX] || s_q.pend[ILM_PB_UART_RX])
         && s_q.mask[ILM_LV_UART] |=> level_req[ILM_LV_UART];
   endproperty
   a_flags_level: assert property (p_flags_level)
      else $error("level 5 missing for uart flags");

   property p_serial_level;
      src.serial_req && s_q.mask[ILM_LV_SER] |=> level_req[ILM_LV_SER];
   endproperty
   a_serial_level: assert property (p_serial_level)
      else $error("level 4 missing for serial port");

   property p_t0_level;
      src.t0_match_req && s_q.mask[ILM_LV_T0] |=> level_req[ILM_LV_T0];
   endproperty
   a_t0_level: assert property (p_t0_level)
      else $error("level 2 missing for timer 0");

   property p_tb_level;
      src.tb_match_req && s_q.mask[ILM_LV_TB] |=> level_req[ILM_LV_TB];
   endproperty
   a_tb_level: assert property (p_tb_level)
      else $error("level 1 missing for timer b");

   property p_pend_read;
      sfr_req.rd && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR
         |=> sfr_rdata == {ILM_PEND_UNUSED, $past(s_q.pend)};
   endproperty
   a_pend_read: assert property (p_pend_read)
      else $error("pending byte readback wrong");

   property p_pend_update;
      sfr_req.wr && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR
         |=> s_q.pend == (($past(s_q.pend) & $past(sfr_req.wdata[5:0]))
         | $past(src.pend_event));
   endproperty
   a_pend_update: assert property (p_pend_update)
      else $error("pending write result wrong");

   property p_pend_idle;
      !(sfr_req.wr && sfr_req.addr == ILM_SERIAL_PENDING_FLAGS_ADDR)
         && src.pend_event == 6'h00 |=> $stable(s_q.pend);
   endproperty
   a_pend_idle: assert property (p_pend_idle)
      else $error("pending flag moved on its own");
endmodule

// File: ilm_pkg.sv
/*
 * constants and carrier types for the interrupt level mask and the
 * serial pending flags.
 * assumes a core that reaches special registers by an 8-bit address.
 */
package ilm_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ILM_LEVEL_ENABLE_MASK_ADDR = 8'hDD;
   localparam logic [7:0] ILM_SERIAL_PENDING_FLAGS_ADDR = 8'hF9;
   // mask powers up masked: nothing reaches the core before setup
   localparam logic [7:0] ILM_MASK_RESET = 8'h00;
   localparam logic [5:0] ILM_PEND_RESET = 6'h00;
   localparam logic [7:0] ILM_READ_UNMAPPED = 8'h00;
   localparam logic [1:0] ILM_PEND_UNUSED = 2'h0;
   localparam int ILM_NUM_LEVELS = 8;
   localparam int ILM_NUM_PEND = 6;

   // ----------------------------------------------------------------
   // pending flag bit positions
   // ----------------------------------------------------------------
   localparam int ILM_PB_TA_OVF = 0;
   localparam int ILM_PB_TA_CAP = 1;
   localparam int ILM_PB_T1_OVF = 2;
   localparam int ILM_PB_T1_CAP = 3;
   localparam int ILM_PB_UART_TX = 4;
   localparam int ILM_PB_UART_RX = 5;

   // ----------------------------------------------------------------
   // level numbers
   // ----------------------------------------------------------------
   localparam int ILM_LV_TA = 0;
   localparam int ILM_LV_TB = 1;
   localparam int ILM_LV_T0 = 2;
   localparam int ILM_LV_T1 = 3;
   localparam int ILM_LV_SER = 4;
   localparam int ILM_LV_UART = 5;
   localparam int ILM_LV_P0_LO = 6;
   localparam int ILM_LV_P0_HI = 7;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ilm_sfr_req_t;

   typedef struct packed {
      logic [5:0] pend_event;   // one-cycle events, by pending bit
      logic watch_timer_req;
      logic serial_req;
      logic t0_match_req;
      logic tb_match_req;
   } ilm_src_t;

   typedef struct packed {
      logic [7:0] mask;
      logic [5:0] pend;
      logic [7:0] pin_s1;
      logic [7:0] pin_s2;
      logic [7:0] level_req;
      logic [7:0] rdata;
   } ilm_state_t;
endpackage

// File: tb.sv
/* bench for ilm_level_mask: seeded random and corner cases.
   assumes the core model in ilm_core.sv. */
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
   n_mismatch++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb
   import ilm_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1;
   logic [7:0] pins = '0, q, m, lf = 8'h4E, lv;
   ilm_src_t src = '0;
   ilm_sfr_req_t req;
   logic [7:0] rdata;
   int n_mismatch = 0, compares = 0, cyc = 0;
   always #10 clk = ~clk;
   ilm_level_mask dut_u (.clk(clk), .rst(rst), .sfr_req(req),
      .sfr_rdata(rdata), .port0_pin(pins), .src(src), .level_req(lv));
   ilm_core core_u (.clk(clk), .req(req), .rdata(rdata));
   function automatic logic [7:0] nxt(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] xl(logic [7:0] k, p, logic [5:0] d,
      ilm_src_t s);
      return k & {|p[7:4], |p[3:0], d[5] | d[4] | s.watch_timer_req,
         s.serial_req, d[3] | d[2], s.t0_match_req, s.tb_match_req,
         d[1] | d[0]};
   endfunction
   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // hard ceiling: whole run needs well under 2000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic pulse(logic [5:0] e);
      @(posedge clk) src.pend_event <= e;
      @(posedge clk) src.pend_event <= '0;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      core_u.acc(1'b0, ILM_LEVEL_ENABLE_MASK_ADDR, 8'h00, q);
      `CHK(q, ILM_MASK_RESET)
      core_u.acc(1'b0, ILM_SERIAL_PENDING_FLAGS_ADDR, 8'h00, q);
      `CHK(q, 8'h00)
      core_u.acc(1'b0, 8'h42, 8'h00, q);
      `CHK(q, ILM_READ_UNMAPPED)
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         lf = nxt(lf);
         m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lf;
         core_u.acc(1'b1, ILM_LEVEL_ENABLE_MASK_ADDR, m, q);
         core_u.acc(1'b0, ILM_LEVEL_ENABLE_MASK_ADDR, 8'h00, q);
         `CHK(q, m)
         lf = nxt(lf);
         pins <= lf;
         lf = nxt(lf);
         src <= {6'h00, lf[3:0]};
         repeat (4) @(posedge clk);
         `CHK(lv, xl(m, pins, 6'h00, src))
      end
      $display("test mask done");
      pins <= '0;
      src <= '0;
      core_u.acc(1'b1, ILM_LEVEL_ENABLE_MASK_ADDR, 8'hFF, q);
      // unmapped write must leave the mask alone
      core_u.acc(1'b1, 8'h42, 8'h00, q);
      core_u.acc(1'b0, ILM_LEVEL_ENABLE_MASK_ADDR, 8'h00, q);
      `CHK(q, 8'hFF)
      for (int b = 0; b < 6; b++) begin
         pulse(6'(1 << b));
         core_u.acc(1'b0, ILM_SERIAL_PENDING_FLAGS_ADDR, 8'h00, q);
         `CHK(q, 8'(1 << b))
         `CHK(lv, xl(8'hFF, 8'h00, 6'(1 << b), src))
         core_u.acc(1'b1, ILM_SERIAL_PENDING_FLAGS_ADDR, 8'h00, q);
         core_u.acc(1'b0, ILM_SERIAL_PENDING_FLAGS_ADDR, 8'h00, q);
         `CHK(q, 8'h00)
      end
      pulse(6'h30);
      fork
         core_u.acc(1'b1, ILM_SERIAL_PENDING_FLAGS_ADDR, 8'h00, q);
         pulse(6'h20);
      join
      core_u.acc(1'b0, ILM_SERIAL_PENDING_FLAGS_ADDR, 8'h00, q);
      `CHK(q, 8'h20)
      core_u.acc(1'b1, ILM_LEVEL_ENABLE_MASK_ADDR, 8'hDF, q);
      // new mask reaches level_req on the edge the task returns on
      @(posedge clk);
      `CHK(lv, 8'h00)
      $display("test pending done");
      results();
   end
endmodule
